/* File: rtl/smmc_top.sv */
// Slave-mode memory controller: bank decode, strobes, refresh and AXI4-Lite registers
`include "smmc_consts.svh"
module smmc_top (
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite write address/data/response
  input  wire logic [11:0]       s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read
  input  wire logic [11:0]       s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // External master bus (pins, asynchronous)
  input  wire logic              addr_strobe_n,
  input  wire logic [31:0]       ext_addr,
  input  wire logic [3:0]        ext_fc,
  input  wire logic              ext_rw,
  input  wire logic [3:0]        ext_parity,
  output logic [1:0]             size_acknowledge_n,
  // Memory side
  output logic [7:0]             chip_select_n,
  output logic [3:0]             column_strobe_n,
  output logic [3:0]             byte_we_n,
  output logic                   addr_mux_select,
  output logic                   row_strobe_double_drive_n,
  output logic                   parity_error,
  // Pin routing view
  output logic [15:0]            port_e_pin_assign
);
  import smmc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [31:0]      gmc_r;
  logic [15:0]      memory_status_r;
  logic [31:0]      base_r [8];
  logic [31:0]      opt_r  [8];
  smmc_state_t      st_r, st_nxt;
  logic [3:0]       wait_r;
  logic [2:0]       bank_r;
  logic [16:0]      page_r;
  logic             page_ok_r;

  // Global fields
  wire       sync_mode = gmc_r[`SMMC_GMC_SYNC];
  wire [2:0] pgs       = gmc_r[`SMMC_GMC_PGS_LSB +: 3];
  wire [1:0] dram_port_size       = gmc_r[`SMMC_GMC_DPS_LSB +: 2];
  wire       rf_en     = gmc_r[`SMMC_GMC_REFRESH_ENABLE];

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: two flops; strobe enters active high so reset reads idle
  logic        as_s;
  logic [31:0] addr_s;
  logic [3:0]  fc_s;
  logic        rw_s;
  logic [3:0]  par_s;
  smmc_sync2 #(.W(42)) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       ({!addr_strobe_n, ext_addr, ext_fc, ext_rw, ext_parity}),
    .q       ({as_s, addr_s, fc_s, rw_s, par_s})
  );
  // A strobe negation shorter than a clock may vanish in the sync path
  wire as_live = as_s;

  ////////////////////////////////////////////////////////////////////////////
  // Bank decode, one match per bank
  logic [7:0] hit;
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_bank
      wire [16:0] am     = opt_r[g][`SMMC_OR_AM_LSB +: 17];
      wire [16:0] ba     = base_r[g][`SMMC_BR_BA_LSB +: 17];
      wire [3:0]  fcm    = opt_r[g][`SMMC_OR_FCM_LSB +: 4];
      wire [3:0]  fcb    = base_r[g][`SMMC_BR_FC_LSB +: 4];
      wire        a_ok   = ((addr_s[27:11] ^ ba) & am) == 17'h0_0000;
      wire        fc_ok  = (((fc_s ^ fcb) & ~fcm) == 4'h0) && (fc_s != `SMMC_FC_CPU_SPACE);
      assign hit[g] = base_r[g][`SMMC_BR_V] && a_ok && fc_ok;
    end
  endgenerate

  // Lowest bank wins on overlap
  logic [2:0] hit_idx;
  always_comb begin
    hit_idx = 3'd0;
    for (int i = 7; i >= 0; i--) begin
      if (hit[i]) hit_idx = 3'(i);
    end
  end
  wire        any_hit = |hit;
  wire [31:0] sel_or  = opt_r[bank_r];
  wire [31:0] sel_br  = base_r[bank_r];
  wire        is_dram = sel_or[`SMMC_OR_DRAM_SELECT];
  wire        page_mode_enable    = sel_or[`SMMC_OR_PAGE_MODE_ENABLE];
  // Wait count comes from the bank being entered, not the last one
  wire [31:0] hit_or  = opt_r[hit_idx];
  wire [3:0]  bank_cycle_length    = hit_or[`SMMC_OR_BANK_CYCLE_LENGTH_LSB +: 4];

  // Page boundary from page-size code; 011 gives 16 KiB rows (address bits 30:14)
  wire [4:0]  pg_shift  = 5'd9 + {2'b00, pgs};
  wire [16:0] page_cur  = 17'(addr_s[31:11] >> (pg_shift - 5'd9));
  wire        page_hit  = page_ok_r && page_mode_enable && (page_cur == page_r) && (hit_idx == bank_r);
  // Wait states; the external-master wait state only counts in async mode
  wire        ext_master_wait_state      = gmc_r[`SMMC_GMC_EXT_MASTER_WAIT_STATE] && !sync_mode;
  wire        dram_wait_in_page       = gmc_r[`SMMC_GMC_DWQ];
  wire [3:0]  ws_first  = 4'(bank_cycle_length + {3'b000, ext_master_wait_state});
  wire [3:0]  ws_page   = dram_wait_in_page ? 4'd1 : 4'd0;

  // Port size code to acknowledge pattern: 00 is 32-bit
  function automatic smmc_size_t ack_code(input logic [1:0] ps);
    case (ps)
      2'b01:   ack_code = 2'b10;  // 8-bit
      2'b10:   ack_code = 2'b01;  // 16-bit
      default: ack_code = 2'b00;  // 32-bit
    endcase
  endfunction
  wire [1:0]  sps       = sel_or[`SMMC_OR_SPS_LSB +: 2];
  wire [1:0]  ack_pat   = is_dram ? ack_code(dram_port_size) : ack_code(sps);

  // Parity of each byte lane, only in synchronous mode
  wire [3:0]  lane_par  = {^addr_s[31:24], ^addr_s[23:16], ^addr_s[15:8], ^addr_s[7:0]};
  wire        par_bad   = sync_mode && sel_br[`SMMC_BR_PAREN] && !rw_s && (lane_par != par_s);
  wire        wp_bad    = sel_br[`SMMC_BR_WP] && !rw_s;

  ////////////////////////////////////////////////////////////////////////////
  // Refresh timer
  logic rf_req;
  wire  rf_done = (st_r == SMMC_RFEND);
  smmc_refresh u_refresh (
    .aclk    (aclk),
    .aresetn (aresetn),
    .enable  (rf_en),
    .count   (gmc_r[`SMMC_GMC_REFRESH_COUNT_LSB +: `SMMC_GMC_REFRESH_COUNT_W]),
    .done    (rf_done),
    .req     (rf_req)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Cycle state machine; refresh goes first only when idle
  wire wait_done = (wait_r == 4'd0);
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      SMMC_IDLE:  if (rf_req) st_nxt = SMMC_RFSH;
                  else if (as_live && any_hit) st_nxt = SMMC_ROW;
      SMMC_ROW:   st_nxt = SMMC_WAIT;
      SMMC_WAIT:  if (wait_done) st_nxt = SMMC_ACK;
      SMMC_ACK:   st_nxt = SMMC_HOLD;
      SMMC_HOLD:  if (!as_live) st_nxt = SMMC_IDLE;
      SMMC_RFSH:  if (wait_done) st_nxt = SMMC_RFEND;
      SMMC_RFEND: st_nxt = SMMC_IDLE;
      default:    st_nxt = SMMC_IDLE;
    endcase
  end

  wire start_acc = (st_r == SMMC_IDLE) && (st_nxt == SMMC_ROW);
  wire start_rf  = (st_r == SMMC_IDLE) && (st_nxt == SMMC_RFSH);
  // Refresh length code stretches the refresh wait
  wire [3:0] rf_wait = 4'(gmc_r[`SMMC_GMC_REFRESH_CYCLE_LENGTH_LSB +: 2] + 2'd2);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r   <= SMMC_IDLE;
      wait_r <= 4'd0;
      bank_r <= 3'd0;
    end else begin
      st_r <= st_nxt;
      if (start_acc) begin
        bank_r <= hit_idx;
        wait_r <= page_hit ? ws_page : ws_first;
      end else if (start_rf) begin
        wait_r <= rf_wait;
      end else if (!wait_done && (st_r == SMMC_WAIT || st_r == SMMC_RFSH)) begin
        wait_r <= wait_r - 4'd1;
      end
    end
  end

  // Open-page tracker for page-mode hits
  always_ff @(posedge aclk) begin
    if (!aresetn || start_rf) begin
      page_ok_r <= 1'b0;
      page_r    <= 17'h0_0000;
    end else if (st_r == SMMC_ROW) begin
      page_ok_r <= is_dram;
      page_r    <= page_cur;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Memory strobes, all registered
  wire in_acc = (st_r == SMMC_ROW) || (st_r == SMMC_WAIT) || (st_r == SMMC_ACK);
  wire in_rf  = (st_r == SMMC_RFSH);
  wire col_ph = (st_r == SMMC_WAIT) || (st_r == SMMC_ACK);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chip_select_n             <= 8'hFF;
      column_strobe_n           <= 4'hF;
      byte_we_n                 <= 4'hF;
      addr_mux_select           <= 1'b0;
      row_strobe_double_drive_n <= 1'b1;
      size_acknowledge_n        <= 2'b11;
    end else begin
      // Refresh strobes every row line of DRAM banks at once
      for (int i = 0; i < 8; i++) begin
        chip_select_n[i] <= !((in_acc && bank_r == 3'(i)) || (in_rf && opt_r[i][`SMMC_OR_DRAM_SELECT]));
      end
      column_strobe_n           <= (is_dram && col_ph) || in_rf ? 4'h0 : 4'hF;
      byte_we_n                 <= (col_ph && !rw_s && !wp_bad) ? ~addr_s[31:28] : 4'hF;
      addr_mux_select           <= is_dram && col_ph;
      row_strobe_double_drive_n <= !((in_acc && bank_r == 3'd1) || (in_rf && opt_r[1][`SMMC_OR_DRAM_SELECT]));
      size_acknowledge_n        <= (st_nxt == SMMC_ACK) ? ack_pat : 2'b11;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave
  logic        aw_held_r, w_held_r;
  logic [11:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  wire         wr_go = aw_held_r && w_held_r && !s_axi_bvalid;
  wire [11:0]  wofs  = awaddr_r - `SMMC_OFS_BANK_BASE;
  wire [2:0]   widx  = wofs[5:3];
  wire         w_bank = (awaddr_r >= `SMMC_OFS_BANK_BASE) && (wofs < 12'h040);
  wire         w_gmc  = awaddr_r == `SMMC_OFS_GMC;
  wire         w_st   = awaddr_r == `SMMC_OFS_MEMORY_STATUS;
  wire         w_pe   = awaddr_r == `SMMC_OFS_PEPA;
  wire         w_ok   = w_gmc || w_st || w_pe || w_bank;
  wire [31:0]  wmask  = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
      awaddr_r  <= 12'h000;
      wdata_r   <= 32'h0000_0000;
      wstrb_r   <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'b00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        awaddr_r  <= {s_axi_awaddr[11:2], 2'b00};
      end else if (wr_go) aw_held_r <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end else if (wr_go) w_held_r <= 1'b0;
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= w_ok ? 2'b00 : 2'b10;
      end else if (s_axi_bready) s_axi_bvalid <= 1'b0;
    end
  end
  assign s_axi_awready = !aw_held_r;
  assign s_axi_wready  = !w_held_r;

  // Register writes; bank registers indexed by stride
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gmc_r             <= `SMMC_GMC_RESET;
      port_e_pin_assign <= `SMMC_PEPA_RESET;
      for (int i = 0; i < 8; i++) begin
        base_r[i] <= 32'h0000_0000;
        opt_r[i]  <= 32'h0000_0000;
      end
    end else if (wr_go) begin
      if (w_gmc) gmc_r <= (gmc_r & ~wmask) | (wdata_r & wmask);
      if (w_pe) port_e_pin_assign <= (port_e_pin_assign & ~wmask[15:0]) | (wdata_r[15:0] & wmask[15:0]);
      if (w_bank && !wofs[2]) base_r[widx] <= (base_r[widx] & ~wmask) | (wdata_r & wmask);
      if (w_bank && wofs[2])  opt_r[widx]  <= (opt_r[widx] & ~wmask) | (wdata_r & wmask);
    end
  end

  // Status: hardware set wins over write-one-to-clear
  wire        acc_ck  = (st_r == SMMC_ROW);
  wire [15:0] st_set  = {14'h0000, acc_ck && par_bad, acc_ck && wp_bad};
  wire [15:0] st_clr  = (wr_go && w_st) ? (wdata_r[15:0] & wmask[15:0]) : 16'h0000;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      memory_status_r      <= 16'h0000;
      parity_error <= 1'b0;
    end else begin
      memory_status_r      <= (memory_status_r & ~st_clr) | st_set;
      parity_error <= memory_status_r[`SMMC_ST_PER];
    end
  end

  // Read channel
  wire [11:0] rofs  = s_axi_araddr - `SMMC_OFS_BANK_BASE;
  wire        r_bank = (s_axi_araddr >= `SMMC_OFS_BANK_BASE) && (rofs < 12'h040);
  wire [11:0] raddr = {s_axi_araddr[11:2], 2'b00};
  wire [31:0] bank_rd = rofs[2] ? opt_r[rofs[5:3]] : base_r[rofs[5:3]];
  wire        r_ok  = r_bank || raddr == `SMMC_OFS_GMC || raddr == `SMMC_OFS_MEMORY_STATUS || raddr == `SMMC_OFS_PEPA;
  wire [31:0] rmux  = r_bank ? bank_rd :
                      raddr == `SMMC_OFS_GMC   ? gmc_r :
                      raddr == `SMMC_OFS_MEMORY_STATUS ? {16'h0000, memory_status_r} :
                      raddr == `SMMC_OFS_PEPA  ? {16'h0000, port_e_pin_assign} : 32'h0000_0000;
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rmux;
      s_axi_rresp  <= r_ok ? 2'b00 : 2'b10;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule // smmc_top

/* File: rtl/smmc_consts.svh */
// Register offsets, field positions, reset values and timing counts of the slave memory controller
`ifndef SMMC_CONSTS_SVH
`define SMMC_CONSTS_SVH
// Register byte offsets (one aligned word each)
`define SMMC_OFS_GMC       12'h000
`define SMMC_OFS_MEMORY_STATUS     12'h004
`define SMMC_OFS_PEPA      12'h008
`define SMMC_OFS_BANK_BASE 12'h100
`define SMMC_OFS_BANK_OPT  12'h104
`define SMMC_BANK_STRIDE   12'h008
// Global memory config fields
`define SMMC_GMC_REFRESH_COUNT_LSB 24
`define SMMC_GMC_REFRESH_COUNT_W   8
`define SMMC_GMC_REFRESH_ENABLE      23
`define SMMC_GMC_REFRESH_CYCLE_LENGTH_LSB  21
`define SMMC_GMC_PGS_LSB   18
`define SMMC_GMC_DPS_LSB   16
`define SMMC_GMC_DWQ       15
`define SMMC_GMC_EXT_MASTER_WAIT_STATE      14
`define SMMC_GMC_SYNC      13
`define SMMC_GMC_GLOBAL_ADDR_MULTIPLEX      12
// Bank base fields
`define SMMC_BR_BA_LSB     11
`define SMMC_BR_FC_LSB     7
`define SMMC_BR_PAREN      3
`define SMMC_BR_WP         1
`define SMMC_BR_V          0
// Bank option fields
`define SMMC_OR_BANK_CYCLE_LENGTH_LSB   28
`define SMMC_OR_AM_LSB     11
`define SMMC_OR_FCM_LSB    7
`define SMMC_OR_PAGE_MODE_ENABLE       3
`define SMMC_OR_SPS_LSB    1
`define SMMC_OR_DRAM_SELECT      0
// Status bits
`define SMMC_ST_WPER       0
`define SMMC_ST_PER        1
// Reset values
`define SMMC_GMC_RESET     32'h0000_0000
`define SMMC_PEPA_RESET    16'h0000
`define SMMC_PEPA_DRAM_SYS 16'h51C0
// Refresh period: 24 prescaled by 16 clocks at 25 MHz gives 16 us
`define SMMC_RF_PRESCALE   8'h10
// CPU-space function code
`define SMMC_FC_CPU_SPACE  4'h7
`endif

/* File: rtl/smmc_pkg.sv */
// Types of the slave memory controller
package smmc_pkg;
  typedef enum logic [2:0] {
    SMMC_IDLE  = 3'b000,
    SMMC_ROW   = 3'b001,
    SMMC_WAIT  = 3'b011,
    SMMC_ACK   = 3'b010,
    SMMC_HOLD  = 3'b110,
    SMMC_RFSH  = 3'b111,
    SMMC_RFEND = 3'b101
  } smmc_state_t;
  typedef logic [1:0] smmc_size_t;
endpackage

/* File: rtl/smmc_sync2.sv */
// Two-flop synchroniser for a bus of pin inputs
module smmc_sync2 #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;
  // First flop feeds only the second
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule // smmc_sync2

/* File: rtl/smmc_refresh.sv */
// Refresh period timer: one request per programmed period
`include "smmc_consts.svh"
module smmc_refresh (
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Control
  input  wire logic       enable,
  input  wire logic [7:0] count,
  input  wire logic       done,
  // Request level, held until serviced
  output logic            req
);
  logic [7:0] pre_r;
  logic [7:0] cnt_r;
  wire        pre_tick = (pre_r == `SMMC_RF_PRESCALE - 8'h01);
  wire        cnt_hit  = pre_tick && (cnt_r >= count);
  // Prescaler then period counter
  always_ff @(posedge aclk) begin
    if (!aresetn || !enable) begin
      pre_r <= 8'h00;
      cnt_r <= 8'h00;
    end else begin
      pre_r <= pre_tick ? 8'h00 : pre_r + 8'h01;
      if (pre_tick) begin
        cnt_r <= cnt_hit ? 8'h00 : cnt_r + 8'h01;
      end
    end
  end
  // A new period wins over a done in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn || !enable) begin
      req <= 1'b0;
    end else if (cnt_hit) begin
      req <= 1'b1;
    end else if (done) begin
      req <= 1'b0;
    end
  end
endmodule // smmc_refresh

/* File: testbench/smmc_top_props.sv */
// Port-level assertions for the slave memory controller
module smmc_top_props (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // Master bus and memory side
  input wire logic        addr_strobe_n,
  input wire logic [1:0]  size_acknowledge_n,
  input wire logic [7:0]  chip_select_n,
  input wire logic [15:0] port_e_pin_assign
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////////////
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid) else $error("write response missing");
  a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_arready_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  a_ack_cause: assert property (size_acknowledge_n != 2'b11
    |-> $past(addr_strobe_n, 1) == 1'b0 && $past(addr_strobe_n, 2) == 1'b0) else $error("ack without strobe");
  a_ack_one_cycle: assert property (size_acknowledge_n != 2'b11 |=> size_acknowledge_n == 2'b11)
    else $error("ack held too long");
  a_ack_after_select: assert property (size_acknowledge_n != 2'b11 |-> $past(chip_select_n) != 8'hFF)
    else $error("ack without select");
  a_pins_by_write: assert property (!$stable(port_e_pin_assign)
    |-> $past(s_axi_wvalid) || $past(s_axi_wvalid, 2)) else $error("pin routing changed alone");
  // Main scenarios reached
  c_ack: cover property (size_acknowledge_n == 2'b00);
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'b10);
  c_refresh: cover property (addr_strobe_n && !chip_select_n[1]);
endmodule // smmc_top_props
////////////////////////////////////////////////////////////////////////
bind smmc_top smmc_top_props u_props (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .addr_strobe_n, .size_acknowledge_n, .chip_select_n, .port_e_pin_assign);

/* File: testbench/smmc_ext_master.sv */
// External bus master model with a monitor of the memory strobes
module smmc_ext_master (
  // Clock
  input wire logic        aclk,
  // Master bus pins
  output logic            addr_strobe_n,
  output logic [31:0]     ext_addr,
  output logic [3:0]      ext_fc,
  output logic            ext_rw,
  output logic [3:0]      ext_parity,
  // Device answers
  input wire logic [1:0]  size_acknowledge_n,
  input wire logic [7:0]  chip_select_n,
  input wire logic [3:0]  column_strobe_n,
  input wire logic [3:0]  byte_we_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] a_q;
  logic [3:0]  fc_q, par_q, cas_seen, we_seen;
  logic [7:0]  cs_seen;
  logic [1:0]  code;
  logic        rw_q, go = 0, drop = 0, acked;
  int          lat, cnt;
  initial {addr_strobe_n, ext_addr, ext_fc, ext_rw, ext_parity} = {1'b1, 32'h0, 4'h0, 1'b1, 4'h0};
  ////////////////////////////////////////////////////////////////////////
  // Sole master: no arbitration; strobe held until answer or drop, idle address, function code and parity lines toggle
  always @(posedge aclk) begin
    if (addr_strobe_n && go) begin
      {addr_strobe_n, ext_addr, ext_fc, ext_rw, ext_parity} <= {1'b0, a_q, fc_q, rw_q, par_q};
      {cnt, cs_seen, cas_seen, we_seen} <= {32'd0, 8'hFF, 4'hF, 4'hF};
    end else if (!addr_strobe_n) begin
      cnt <= cnt + 1;
      {cs_seen, cas_seen, we_seen} <= {cs_seen & chip_select_n, cas_seen & column_strobe_n, we_seen & byte_we_n};
      if (size_acknowledge_n !== 2'b11 || drop) begin
        {addr_strobe_n, acked, code} <= {1'b1, size_acknowledge_n !== 2'b11, size_acknowledge_n};
        lat <= cnt;
      end
    end else begin
      {ext_addr, ext_fc, ext_parity} <= ~{ext_addr, ext_fc, ext_parity};
    end
  end
  // One bus cycle; abandoned after 40 clocks without answer
  task automatic cycle(input logic [31:0] a, input logic [3:0] fc, input logic rw, input logic [3:0] par);
    {a_q, fc_q, rw_q, par_q, go} <= {a, fc, rw, par, 1'b1};
    wait (!addr_strobe_n);
    go <= 0;
    repeat (40) @(posedge aclk);
    drop <= !addr_strobe_n;
    wait (addr_strobe_n);
    @(posedge aclk) drop <= 0;
    repeat (4) @(posedge aclk);
  endtask
endmodule // smmc_ext_master

/* File: testbench/smmc_top_tb.sv */
// Self-checking bench: registers over AXI4-Lite, bank decode, wait states, refresh
`include "smmc_consts.svh"
module smmc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 0, aresetn = 0;
  logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, ext_addr, d, e, seed = 32'h0000_3609;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, addr_strobe_n, ext_rw;
  logic [1:0] s_axi_bresp, s_axi_rresp, size_acknowledge_n;
  logic [3:0] ext_fc, ext_parity, column_strobe_n, byte_we_n;
  logic [7:0] chip_select_n;
  logic [15:0] port_e_pin_assign;
  logic [1:0] bq[$];
  logic [33:0] rq[$];
  int bad_count = 0, num_checks = 0, l1, t, k;
  logic p;
  always #12.5 aclk = ~aclk;
  smmc_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .addr_strobe_n, .ext_addr, .ext_fc, .ext_rw, .ext_parity, .size_acknowledge_n, .chip_select_n,
    .column_strobe_n, .byte_we_n, .addr_mux_select(), .row_strobe_double_drive_n(), .parity_error(),
    .port_e_pin_assign);
  smmc_ext_master u_mst (.aclk, .addr_strobe_n, .ext_addr, .ext_fc, .ext_rw, .ext_parity,
    .size_acknowledge_n, .chip_select_n, .column_strobe_n, .byte_we_n);
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [11:0] bk(input int n, input logic [11:0] ofs);
    return 12'(ofs + `SMMC_BANK_STRIDE * n);
  endfunction
  task automatic check(input string nm, input logic [33:0] seen, input logic [33:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic complete_run();
    if (bad_count == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // AXI4-Lite write: both channels offered together, each released when taken
  task automatic wr(input logic [11:0] a, input logic [31:0] dv, input logic [1:0] er);
    logic aw_hs, w_hs;
    bq.push_back(er);
    {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, dv, 3'b111};
    do begin
      @(negedge aclk);
      {aw_hs, w_hs} = {s_axi_awvalid & s_axi_awready, s_axi_wvalid & s_axi_wready};
      @(posedge aclk);
      if (aw_hs) s_axi_awvalid <= 0;
      if (w_hs) s_axi_wvalid <= 0;
    end while ((s_axi_awvalid && !aw_hs) || (s_axi_wvalid && !w_hs));
    do @(negedge aclk); while (!s_axi_bvalid);
    @(posedge aclk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [33:0] ex);
    rq.push_back(ex);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
    do @(negedge aclk); while (!s_axi_arready);
    @(posedge aclk);
    s_axi_arvalid <= 0;
    do @(negedge aclk); while (!s_axi_rvalid);
    @(posedge aclk);
  endtask
  // One master cycle; answer, size code, selects and write lanes compared at once
  task automatic bus(input logic [31:0] a, input logic [3:0] f, input logic rw, input logic [7:0] cs,
                     input logic ack, input logic [3:0] we);
    u_mst.cycle(a, f, rw, 4'(xs()));
    check("bus", {u_mst.acked, u_mst.code, u_mst.cs_seen, u_mst.we_seen}, {ack, ack ? 2'b00 : 2'b11, cs, we});
  endtask
  // Answers taken off the oldest notes
  always @(posedge aclk) begin
    if (s_axi_bvalid && s_axi_bready) check("bresp", s_axi_bresp, bq.pop_front());
    if (s_axi_rvalid && s_axi_rready) check("rdata", {s_axi_rresp, s_axi_rdata}, rq.pop_front());
  end
  initial begin
    repeat (20000) @(posedge aclk);
    bad_count++;
    complete_run();
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    rd(`SMMC_OFS_GMC, 0);
    rd(`SMMC_OFS_MEMORY_STATUS, 0);
    wr(`SMMC_OFS_PEPA, 32'h0000_51C0, 0);
    rd(`SMMC_OFS_PEPA, 34'h0_0000_51C0);
    check("pins", port_e_pin_assign, 16'h51C0);
    wr(12'h800, xs(), 2'b10);
    rd(12'h800, {2'b10, 32'h0});
    // Random field values on every bank, valid bit left clear
    for (int n = 0; n < 8; n++) begin
      d = xs() & 32'h0FFF_FF8A;
      e = xs() & 32'hFFFF_FF8F;
      wr(bk(n, `SMMC_OFS_BANK_BASE), d, 0);
      wr(bk(n, `SMMC_OFS_BANK_OPT), e, 0);
      rd(bk(n, `SMMC_OFS_BANK_BASE), {2'b00, d});
      rd(bk(n, `SMMC_OFS_BANK_OPT), {2'b00, e});
    end
    wr(`SMMC_OFS_GMC, 32'h0000_2000, 0);
    wr(bk(1, `SMMC_OFS_BANK_BASE), 32'h0020_0001, 0);
    wr(bk(1, `SMMC_OFS_BANK_OPT), 32'h0FF0_0781, 0);
    wr(bk(3, `SMMC_OFS_BANK_BASE), 32'h0010_0001, 0);
    wr(bk(3, `SMMC_OFS_BANK_OPT), 32'h2FF0_0780, 0);
    wr(bk(5, `SMMC_OFS_BANK_BASE), 32'h0030_0003, 0);
    wr(bk(5, `SMMC_OFS_BANK_OPT), 32'h0FF0_0780, 0);
    wr(bk(6, `SMMC_OFS_BANK_BASE), 32'h0040_0000, 0);
    wr(bk(6, `SMMC_OFS_BANK_OPT), 32'h0FF0_0780, 0);
    for (int f = 0; f < 8; f++) bus(32'h0010_0040, 4'(f), 1, f == 7 ? 8'hFF : 8'hF7, f != 7, 4'hF);
    bus(32'hF010_0040, 4'h1, 0, 8'hF7, 1, 4'h0);
    l1 = u_mst.lat;
    check("sram strobes", u_mst.cas_seen, 4'hF);
    bus(32'h0020_0010, 4'h5, 1, 8'hFD, 1, 4'hF);
    check("dram strobes", u_mst.cas_seen !== 4'hF, 1);
    bus(32'h0040_0000, 4'h5, 1, 8'hFF, 0, 4'hF);
    bus(32'hF030_0000, 4'h2, 0, 8'hDF, 1, 4'hF);
    rd(`SMMC_OFS_MEMORY_STATUS, 34'h0_0000_0001);
    wr(`SMMC_OFS_MEMORY_STATUS, 32'h0000_0001, 0);
    rd(`SMMC_OFS_MEMORY_STATUS, 0);
    wr(bk(3, `SMMC_OFS_BANK_OPT), 32'h5FF0_0780, 0);
    bus(32'h0010_0040, 4'h5, 1, 8'hF7, 1, 4'hF);
    check("wait states", u_mst.lat - l1, 3);
    wr(`SMMC_OFS_GMC, 32'h0000_6000, 0);
    bus(32'h0010_0040, 4'h5, 1, 8'hF7, 1, 4'hF);
    check("sync wait", u_mst.lat - l1, 3);
    // Page mode on the DRAM bank: a second access in the open row is shorter
    wr(`SMMC_OFS_GMC, 32'h000C_A000, 0);
    wr(bk(1, `SMMC_OFS_BANK_OPT), 32'h4FF0_0789, 0);
    bus(32'h0020_0010, 4'h5, 1, 8'hFD, 1, 4'hF);
    l1 = u_mst.lat;
    bus(32'h0020_0020, 4'h5, 1, 8'hFD, 1, 4'hF);
    check("page hit", l1 - u_mst.lat, 3);
    // Refresh period from two row strobe falls with the bus idle
    wr(`SMMC_OFS_GMC, 32'h0280_2000, 0);
    {t, k, p} = {32'd0, 32'd0, 1'b1};
    for (int i = 0; i < 300 && k < 2; i++) begin
      @(posedge aclk);
      if (p && !chip_select_n[1]) begin
        k++;
        t = (k == 1) ? i : i - t;
      end
      p = chip_select_n[1];
    end
    check("refresh period", t, 48);
    complete_run();
  end
endmodule // smmc_top_tb
